// ==== hdl/mod_major_opcode_decoder.sv ====
`timescale 1ns/100ps

// Function
// RL1: Major opcode is column bits MSB..MSB-2 followed by row bits MSB-3..MSB-5.
// RL2: Opcode MSB is bit 15 for short words, bit 31 for wide words.
// RL3: Pool encodings go to minor decoding; other assigned encodings name one instruction.
// RL4: Reserved-for-future encodings raise Reserved Instruction and perform nothing.
// RL5: Field-class encodings select nothing alone; their sub-table field decides.
// RL6: Higher-level or newer-revision encodings raise Reserved Instruction here.
// RL7: Wide float encodings need 64-bit float enabled, else RI or Coprocessor Unusable.
// RL8: Corrected wide encodings are legal from release 2 regardless of register width.
// RL9: Unimplemented partner encodings raise RI, or Coprocessor Unusable if inaccessible.
// RL10: Optional debug encodings raise RI when omitted, match exactly when present.
// RL11: Extension-reserved encodings raise RI when the extension is absent.
// RL12: Major value 111111 maps directly to the wide word load.
// RL13: Short subtract unsigned goes through short pool A, major 000001.
// RL14: Row 000 columns 000 to 011 are four wide pools; rest branches.
// RL15: Row 001: columns 000-010 short pools, 011 gp load, 100-111 reserved.
// RL16: Row 011 columns 010 and 011 are short pools D and E.
// RL17: The major field is always exactly six bits wide.
// RL18: An instruction size indication derives from the major opcode.
// RL19: Classification and exception requests form combinationally in one stage.
module mod_major_opcode_decoder
	import mod_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	output logic irq,
	output mod_result_type dec
);

	////////////////////////////////////////////////////////////////////////////////
	// Major table lookup, indexed by row then column
	function automatic mod_class_type mod_major_class(input logic [5:0] op);
		logic [2:0] col;
		logic [2:0] row;
		mod_class_type cl;
		col = op[5:3];
		row = op[2:0];
		cl = MOD_CL_DIRECT;
		unique case (row)
			// RL14: wide pool row
			3'h0: cl = (col <= 3'h3) ? MOD_CL_POOL : MOD_CL_DIRECT;
			3'h1: begin
				// RL15: short pools, gp load, reserved
				if (col <= 3'h2)
					cl = MOD_CL_POOL;
				else if (col == 3'h3)
					cl = MOD_CL_DIRECT;
				else
					cl = MOD_CL_RESERVED;
			end
			3'h2: cl = MOD_CL_DIRECT;
			// RL16: pools D and E
			3'h3: cl = (col == 3'h2 || col == 3'h3) ? MOD_CL_POOL : MOD_CL_DIRECT;
			3'h4: cl = (col == 3'h7) ? MOD_CL_HIGHER : MOD_CL_DIRECT;
			3'h5: cl = (col == 3'h2) ? MOD_CL_POOL : MOD_CL_DIRECT;
			3'h6: begin
				if (col == 3'h2)
					cl = MOD_CL_RESERVED;
				else if (col == 3'h5 || col == 3'h6)
					cl = MOD_CL_HIGHER;
				else
					cl = MOD_CL_DIRECT;
			end
			3'h7: begin
				// RL12: column 7 stays direct
				if (col == 3'h2 || col == 3'h5 || col == 3'h6)
					cl = MOD_CL_HIGHER;
				else
					cl = MOD_CL_DIRECT;
			end
		endcase
		return cl;
	endfunction : mod_major_class

	// Rows 1 to 3 hold the short encodings
	function automatic logic mod_is_short(input logic [5:0] op);
		return (op[2:0] >= 3'h1) && (op[2:0] <= 3'h3);
	endfunction : mod_is_short

	// Exception request for a class, returned as {cpu, ri}
	function automatic logic [1:0] mod_resolve(input mod_class_type cl, input mod_ctrl_type c);
		logic cop_block;
		logic [1:0] res;
		cop_block = c.cop_target & ~c.cop_access;
		res = 2'h0;
		unique case (cl)
			MOD_CL_DIRECT, MOD_CL_POOL: res = 2'h0;
			// RL4: reserved for future use
			// RL6: higher level or newer revision
			MOD_CL_RESERVED, MOD_CL_HIGHER: res = 2'h1;
			// RL7: wide float gating
			MOD_CL_WIDE_FP: res = c.fp64_en ? 2'h0 : (cop_block ? 2'h2 : 2'h1);
			// RL8: legal from release 2
			MOD_CL_CORRECTED: res = c.release2 ? 2'h0 : 2'h1;
			// RL9: partner space fallback
			MOD_CL_PARTNER: res = c.partner_impl ? 2'h0 : (cop_block ? 2'h2 : 2'h1);
			// RL10: optional debug support
			MOD_CL_DEBUG: res = c.debug_impl ? 2'h0 : 2'h1;
			// RL11: absent extension
			MOD_CL_ASE: res = c.ase_impl ? 2'h0 : 2'h1;
			// Unassigned minor class codes are treated as reserved
			default: res = 2'h1;
		endcase
		return res;
	endfunction : mod_resolve

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [31:0] instr_ff;
	mod_ctrl_type ctrl_ff;
	mod_result_type result_ff;
	logic [MOD_IRQ_W-1:0] stat_ff;
	logic [MOD_IRQ_W-1:0] mask_ff;
	logic eval_ff;
	logic dp_wr_ff;
	logic [MOD_ADDR_W-1:0] dp_addr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic [1:0] hresp_ff;
	logic irq_ff;

	logic ap_valid;
	logic [5:0] op_c;
	mod_class_type major_cls_c;
	mod_class_type eff_cls_c;
	logic [1:0] exc_c;
	mod_result_type nxt_result;
	logic [MOD_IRQ_W-1:0] stat_set;
	logic [MOD_IRQ_W-1:0] stat_clr;
	logic [MOD_IRQ_W-1:0] nxt_stat;
	logic [31:0] nxt_hrdata;

	////////////////////////////////////////////////////////////////////////////////
	// Decode datapath, purely combinational from the held word and enables

	// RL2: choose the parcel that holds the opcode
	// RL17: always a six-bit slice
	assign op_c = ctrl_ff.low_half ? instr_ff[MOD_MSB_SHORT -: MOD_OP_W]
		: instr_ff[MOD_MSB_WIDE -: MOD_OP_W];

	// RL1: column bits lead, row bits follow
	assign major_cls_c = mod_major_class(op_c);

	// RL5: pool words take their class from the sub-table field
	assign eff_cls_c = (major_cls_c == MOD_CL_POOL) ? mod_class_type'(ctrl_ff.minor_class)
		: major_cls_c;

	// RL19: exception request in the same stage
	assign exc_c = mod_resolve(eff_cls_c, ctrl_ff);

	// Result assembly
	always_comb begin
		nxt_result = MOD_RESULT_RST;
		nxt_result.major = op_c;
		// RL18: size from the major opcode
		nxt_result.size32 = ~mod_is_short(op_c);
		// RL3: pool versus direct
		// RL13: pool A carries the short subtract
		nxt_result.needs_minor = (major_cls_c == MOD_CL_POOL);
		nxt_result.direct = (major_cls_c == MOD_CL_DIRECT);
		nxt_result.ri = exc_c[0];
		nxt_result.cpu = exc_c[1];
		nxt_result.legal = ~exc_c[0] & ~exc_c[1];
		nxt_result.cls = eff_cls_c;
	end

	// Registered copy for the pipeline port and software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			result_ff <= MOD_RESULT_RST;
		else
			result_ff <= nxt_result;
	end

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY

	// Only word transfers are accepted; other sizes pass unanswered in effect
	assign ap_valid = hsel & htrans[1] & hready & (hsize == MOD_HSIZE_WORD);

	// Address phase capture for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= '0;
		end else begin
			dp_wr_ff <= ap_valid & hwrite;
			if (ap_valid)
				dp_addr_ff <= haddr[MOD_ADDR_W-1:0];
		end
	end

	// Writable registers, taken at the end of the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_ff <= 32'h0000_0000;
			ctrl_ff <= MOD_CTRL_RST;
			mask_ff <= MOD_IRQ_RST;
		end else if (dp_wr_ff) begin
			if (dp_addr_ff == MOD_OFF_INSTR)
				instr_ff <= hwdata;
			if (dp_addr_ff == MOD_OFF_CTRL)
				ctrl_ff <= hwdata[MOD_CTRL_W-1:0];
			if (dp_addr_ff == MOD_OFF_IRQ_MASK)
				mask_ff <= hwdata[MOD_IRQ_W-1:0];
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		nxt_hrdata = 32'h0000_0000;
		unique case (haddr[MOD_ADDR_W-1:0])
			MOD_OFF_INSTR: nxt_hrdata = instr_ff;
			MOD_OFF_CTRL: nxt_hrdata[MOD_CTRL_W-1:0] = ctrl_ff;
			MOD_OFF_RESULT: nxt_hrdata[MOD_RESULT_W-1:0] = result_ff;
			MOD_OFF_IRQ_STAT: nxt_hrdata[MOD_IRQ_W-1:0] = stat_ff;
			MOD_OFF_IRQ_MASK: nxt_hrdata[MOD_IRQ_W-1:0] = mask_ff;
			default: nxt_hrdata = 32'h0000_0000;
		endcase
	end

	// Read data is loaded at the address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_ff <= 32'h0000_0000;
		else if (ap_valid && !hwrite)
			hrdata_ff <= nxt_hrdata;
	end

	// Handshake outputs are held constant, but kept as flops for clean timing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= MOD_HRESP_OKAY;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= MOD_HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Exception events and interrupt

	// A fresh word or enable set is judged one cycle after it lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			eval_ff <= 1'b0;
		else
			eval_ff <= dp_wr_ff & ((dp_addr_ff == MOD_OFF_INSTR) | (dp_addr_ff == MOD_OFF_CTRL));
	end

	// Set wins over a write-one clear in the same cycle
	always_comb begin
		stat_set = '0;
		stat_set[MOD_IRQ_RI] = eval_ff & exc_c[0];
		stat_set[MOD_IRQ_CPU] = eval_ff & exc_c[1];
		stat_clr = (dp_wr_ff && dp_addr_ff == MOD_OFF_IRQ_STAT) ? hwdata[MOD_IRQ_W-1:0] : '0;
		nxt_stat = (stat_ff & ~stat_clr) | stat_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stat_ff <= MOD_IRQ_RST;
		else
			stat_ff <= nxt_stat;
	end

	// Level interrupt, one flop behind the status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(stat_ff & mask_ff);
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign hrdata = hrdata_ff;
	assign irq = irq_ff;
	assign dec = result_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_word_load;
		@(posedge hclk) disable iff (!hresetn)
		(op_c == MOD_OP_WIDE_WORD_LOAD) |=> (result_ff.direct && result_ff.size32
			&& result_ff.legal && result_ff.major == $past(op_c));
	endproperty
	a_word_load: assert property (p_word_load) else $error("word load not direct"); // RL12

	property p_pool_a;
		@(posedge hclk) disable iff (!hresetn)
		(op_c == MOD_OP_SHORT_POOL_A) |=> (result_ff.needs_minor && !result_ff.size32);
	endproperty
	a_pool_a: assert property (p_pool_a) else $error("short pool A misrouted"); // RL13

	property p_parcel;
		@(posedge hclk) disable iff (!hresetn)
		ctrl_ff.low_half |-> (op_c == instr_ff[15:10]);
	endproperty
	a_parcel: assert property (p_parcel) else $error("short opcode taken from wrong bits"); // RL2

	property p_row0;
		@(posedge hclk) disable iff (!hresetn)
		(op_c[2:0] == 3'h0) |-> (nxt_result.needs_minor == (op_c[5:3] < 3'h4))
			&& nxt_result.size32;
	endproperty
	a_row0: assert property (p_row0) else $error("row 0 pool split wrong"); // RL14

	property p_row1_rsv;
		@(posedge hclk) disable iff (!hresetn)
		(op_c[2:0] == 3'h1 && op_c[5]) |-> (exc_c == 2'h1) ##1 (result_ff.ri && !result_ff.legal);
	endproperty
	a_row1_rsv: assert property (p_row1_rsv) else $error("reserved row 1 not RI"); // RL15

	property p_row3;
		@(posedge hclk) disable iff (!hresetn)
		(op_c[2:0] == 3'h3) |-> (nxt_result.needs_minor == (op_c[5:4] == 2'h1));
	endproperty
	a_row3: assert property (p_row3) else $error("row 3 pools wrong"); // RL16

	property p_higher;
		@(posedge hclk) disable iff (!hresetn)
		(major_cls_c == MOD_CL_HIGHER) |-> (exc_c == 2'h1) && !nxt_result.direct;
	endproperty
	a_higher: assert property (p_higher) else $error("higher level encoding accepted"); // RL6

	property p_wide_fp;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_WIDE_FP && !ctrl_ff.fp64_en)
			|-> (exc_c == ((ctrl_ff.cop_target && !ctrl_ff.cop_access) ? 2'h2 : 2'h1));
	endproperty
	a_wide_fp: assert property (p_wide_fp) else $error("wide float gating wrong"); // RL7

	property p_partner;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_PARTNER) |-> (exc_c == (ctrl_ff.partner_impl ? 2'h0
			: ((ctrl_ff.cop_target && !ctrl_ff.cop_access) ? 2'h2 : 2'h1)));
	endproperty
	a_partner: assert property (p_partner) else $error("partner encoding wrong"); // RL9

	property p_event;
		@(posedge hclk) disable iff (!hresetn)
		(eval_ff && exc_c[0] && mask_ff[MOD_IRQ_RI]) |=> stat_ff[MOD_IRQ_RI] ##1 irq_ff;
	endproperty
	a_event: assert property (p_event) else $error("RI event lost or no interrupt"); // RL19

	property p_reserved;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_RESERVED)
			|=> (result_ff.ri && !result_ff.legal && !result_ff.direct);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved encoding not refused"); // RL4

	property p_corrected;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_CORRECTED) |-> (exc_c == {1'b0, !ctrl_ff.release2});
	endproperty
	a_corrected: assert property (p_corrected) else $error("corrected encoding gating wrong"); // RL8

	property p_debug;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_DEBUG) |-> (exc_c == {1'b0, !ctrl_ff.debug_impl});
	endproperty
	a_debug: assert property (p_debug) else $error("debug encoding gating wrong"); // RL10

	property p_ase;
		@(posedge hclk) disable iff (!hresetn)
		(eff_cls_c == MOD_CL_ASE) |-> (exc_c == {1'b0, !ctrl_ff.ase_impl});
	endproperty
	a_ase: assert property (p_ase) else $error("extension encoding gating wrong"); // RL11

endmodule : mod_major_opcode_decoder

// ==== hdl/mod_pkg.sv ====
package mod_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] MOD_OFF_INSTR = 8'h00;
	localparam logic [7:0] MOD_OFF_CTRL = 8'h04;
	localparam logic [7:0] MOD_OFF_RESULT = 8'h08;
	localparam logic [7:0] MOD_OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] MOD_OFF_IRQ_MASK = 8'h10;
	localparam int MOD_ADDR_W = 8;

	// Bus encodings
	localparam logic [2:0] MOD_HSIZE_WORD = 3'h2;
	localparam logic [1:0] MOD_HRESP_OKAY = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode field geometry
	localparam int MOD_OP_W = 6;
	localparam int MOD_MSB_WIDE = 31;
	localparam int MOD_MSB_SHORT = 15;
	localparam logic [5:0] MOD_OP_WIDE_WORD_LOAD = 6'h3f;
	localparam logic [5:0] MOD_OP_SHORT_POOL_A = 6'h01;

	// Interrupt status and mask bit positions
	localparam int MOD_IRQ_RI = 0;
	localparam int MOD_IRQ_CPU = 1;
	localparam int MOD_IRQ_W = 2;
	localparam logic [1:0] MOD_IRQ_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Encoding classes, major table and minor sub-table alike
	typedef enum logic [3:0] {
		MOD_CL_DIRECT,
		MOD_CL_POOL,
		MOD_CL_RESERVED,
		MOD_CL_HIGHER,
		MOD_CL_WIDE_FP,
		MOD_CL_CORRECTED,
		MOD_CL_PARTNER,
		MOD_CL_DEBUG,
		MOD_CL_ASE
	} mod_class_type;

	// Control register layout, msb first
	typedef struct packed {
		logic [3:0] minor_class;
		logic cop_target;
		logic partner_impl;
		logic ase_impl;
		logic debug_impl;
		logic release2;
		logic cop_access;
		logic fp64_en;
		logic low_half;
	} mod_ctrl_type;
	localparam int MOD_CTRL_W = 12;
	localparam logic [11:0] MOD_CTRL_RST = 12'h000;

	// Decode result layout, msb first
	typedef struct packed {
		logic [3:0] cls;
		logic legal;
		logic cpu;
		logic ri;
		logic direct;
		logic needs_minor;
		logic size32;
		logic [5:0] major;
	} mod_result_type;
	localparam int MOD_RESULT_W = 16;
	localparam logic [15:0] MOD_RESULT_RST = 16'h0000;

endpackage : mod_pkg

// ==== dv/mod_fetch_model.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Fetch-side master that loads words and controls into the decoder
module mod_fetch_model
	import mod_pkg::*;
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Bus idle from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = MOD_HSIZE_WORD;
		hwdata = 32'h0;
	end

	// Bounded wait for hready; a stalled slave ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			testbench.failures++;
			testbench.close_out();
		end
	endtask : wait_ready

	// Single word transfer; request held until hready seen high
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		hsel <= 1'b1;
		haddr <= {24'h000000, addr};
		hwrite <= wr;
		hsize <= MOD_HSIZE_WORD;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wdata;
		wait_ready();
		rdata = hrdata;
	endtask : xfer
endmodule : mod_fetch_model

// ==== dv/testbench.sv ====
`timescale 1ns/100ps

module testbench
	import mod_pkg::*;
;
	logic hclk;
	logic hresetn;
	wire logic hsel;
	wire logic hwrite;
	wire logic hreadyout;
	wire logic irq;
	wire logic [31:0] haddr;
	wire logic [31:0] hwdata;
	wire logic [31:0] hrdata;
	wire logic [1:0] htrans;
	wire logic [1:0] hresp;
	wire logic [2:0] hsize;
	mod_result_type dec;
	int failures;
	int num_checks;
	logic [31:0] rd;

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz
	initial hclk = 1'b0;
	always #2.5 hclk = ~hclk;

	// Bus master and decoder; hready follows the one slave
	mod_fetch_model fetch_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	mod_major_opcode_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq(irq), .dec(dec));

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		fetch_u.xfer(1'b1, a, d, t);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		fetch_u.xfer(1'b0, a, 32'h0, rd);
		chk(what, rd, exp);
	endtask : rd_chk

	// Reference decode from the major table and the enables; a pool is never direct
	function automatic logic [15:0] expect_dec(input logic [5:0] m, input logic [11:0] c);
		logic [3:0] e;
		logic [2:0] r;
		logic [2:0] k;
		logic pool;
		logic ri;
		logic cpu;
		logic bad;
		r = m[2:0];
		k = m[5:3];
		e = MOD_CL_DIRECT;
		if ((r == 0 && k < 4) || (r == 1 && k < 3) || (r == 3 && k inside {2, 3})
			|| (r == 5 && k == 2)) e = MOD_CL_POOL;
		else if ((r == 1 && k > 3) || (r == 6 && k == 2)) e = MOD_CL_RESERVED;
		else if ((r == 4 && k == 7) || (r == 6 && k inside {5, 6})
			|| (r == 7 && k inside {2, 5, 6})) e = MOD_CL_HIGHER;
		pool = (e == MOD_CL_POOL);
		if (pool) e = c[11:8];
		// Inaccessible coprocessor turns a wide float or partner refusal into an unusable request
		bad = c[7] & ~c[2];
		ri = 1'b0;
		cpu = 1'b0;
		case (e)
			4'h0, 4'h1: ri = 1'b0;
			4'h4: {cpu, ri} = c[1] ? 2'b00 : {bad, ~bad};
			4'h5: ri = ~c[3];
			4'h6: {cpu, ri} = c[6] ? 2'b00 : {bad, ~bad};
			4'h7: ri = ~c[4];
			4'h8: ri = ~c[5];
			default: ri = 1'b1;
		endcase
		return {e, ~(ri | cpu), cpu, ri, ~pool & (e == 4'h0), pool,
			~(r >= 3'h1 && r <= 3'h3), m};
	endfunction : expect_dec

	// Load controls and word, let decode settle, then read it back
	task automatic dec_case(input logic [5:0] m, input logic [11:0] c, input logic [31:0] w);
		logic [15:0] e;
		e = expect_dec(m, c);
		wr(MOD_OFF_CTRL, {20'h0, c});
		wr(MOD_OFF_INSTR, w);
		repeat (2) @(posedge hclk);
		fetch_u.xfer(1'b0, MOD_OFF_RESULT, 32'h0, rd);
		chk("result", rd, {16'h0, e});
		chk("dec", {16'h0, dec}, {16'h0, e});
	endtask : dec_case

	task automatic close_out();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		failures = 0;
		num_checks = 0;
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk("ctrl", MOD_OFF_CTRL, 32'h0);
		rd_chk("mask", MOD_OFF_IRQ_MASK, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		// Word zero after reset: pool major, minor class direct, legal
		chk("reset dec", {16'h0, dec}, 32'h0000_08c0);
		$display("test reset done");
		// Every major once, odd ones in the low parcel and even ones in the high, junk in the other half
		for (int i = 0; i < 64; i++) begin
			if (i[0]) dec_case(i[5:0], 12'h001, {~i[5:0], 10'h155, i[5:0], 10'h2aa});
			else dec_case(i[5:0], 12'h000, {i[5:0], 26'h2aaaaaa});
		end
		dec_case(MOD_OP_WIDE_WORD_LOAD, 12'h000, 32'hfc000000);
		dec_case(MOD_OP_SHORT_POOL_A, 12'h001, 32'h00000400);
		$display("test major table done");
		// Every sub-table class against every enable combination
		for (int k = 0; k < 16; k++) begin
			for (int j = 0; j < 128; j++) begin
				if (j[0]) dec_case(6'h15, {k[3:0], j[6:0], 1'b0}, 32'h54000000);
				else dec_case(6'h13, {k[3:0], j[6:0], 1'b0}, 32'h4c000000);
			end
		end
		$display("test classes done");
		// Events: raise, mask, clear
		wr(MOD_OFF_IRQ_STAT, 32'h3);
		wr(MOD_OFF_IRQ_MASK, 32'h1);
		dec_case(6'h21, 12'h000, 32'h84000000);
		rd_chk("stat", MOD_OFF_IRQ_STAT, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		dec_case(6'h00, 12'h680, 32'h0);
		rd_chk("stat", MOD_OFF_IRQ_STAT, 32'h3);
		wr(MOD_OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(MOD_OFF_IRQ_MASK, 32'h2);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(MOD_OFF_IRQ_STAT, 32'h2);
		repeat (2) @(posedge hclk);
		rd_chk("stat", MOD_OFF_IRQ_STAT, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		// Unmapped place reads zero and ignores writes
		wr(8'h14, 32'hffffffff);
		rd_chk("unmapped", 8'h14, 32'h0);
		chk("hresp", hresp, {30'h0, MOD_HRESP_OKAY});
		$display("test events done");
		close_out();
	end
endmodule : testbench
